// ==== rtl/ssrp_pkg.sv ====
// shared constants for the sensor serial register port
package ssrp_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned PAGES = 8;
    localparam logic [7:0] PAGE_FIRST = 8'h02;
    localparam logic [7:0] PAGE_LAST = 8'h09;
    localparam logic [7:0] READ_FLAG = 8'h80;
    localparam logic [7:0] ADDR_LAST = 8'hFE;
    // register offsets, control page
    localparam logic [7:0] OFS_SLEEP = 8'h00;
    localparam logic [7:0] OFS_LANE_STBY = 8'h05;
    localparam logic [7:0] OFS_HOLD = 8'h0C;
    localparam logic [7:0] OFS_MSTOP = 8'h12;
    localparam logic [7:0] OFS_TRIG = 8'h13;
    localparam logic [7:0] OFS_ADRES = 8'h14;
    localparam logic [7:0] OFS_FORMAT = 8'h15;
    localparam logic [7:0] OFS_FLIP = 8'h16;
    localparam logic [7:0] OFS_FLINES_LO = 8'h17;
    localparam logic [7:0] OFS_FLINES_HI = 8'h18;
    localparam logic [7:0] OFS_LCLK_LO = 8'h1A;
    localparam logic [7:0] OFS_LCLK_HI = 8'h1B;
    localparam logic [7:0] OFS_OWIDTH = 8'h1C;
    // reset values
    localparam logic [7:0] RST_SLEEP = 8'h01;
    localparam logic [7:0] RST_LANE_STBY = 8'h00;
    localparam logic [7:0] RST_HOLD = 8'h00;
    localparam logic [7:0] RST_MSTOP = 8'h01;
    localparam logic [7:0] RST_TRIG = 8'h00;
    localparam logic [7:0] RST_ADRES = 8'h01;
    localparam logic [7:0] RST_FORMAT = 8'h00;
    localparam logic [7:0] RST_FLIP = 8'h00;
    localparam logic [7:0] RST_FLINES_LO = 8'hE6;
    localparam logic [7:0] RST_FLINES_HI = 8'h04;
    localparam logic [7:0] RST_LCLK_LO = 8'hCE;
    localparam logic [7:0] RST_LCLK_HI = 8'h01;
    localparam logic [7:0] RST_OWIDTH = 8'h11;
    // host controller registers on AHB-Lite (byte addresses)
    localparam logic [7:0] HOFS_CMD = 8'h00;
    localparam logic [7:0] HOFS_STATUS = 8'h04;
    localparam logic [7:0] HOFS_DATA = 8'h08;
    localparam logic [7:0] HOFS_RDATA = 8'h0C;
    localparam int unsigned SCK_HALF = 4;
    localparam logic [31:0] HRDATA_RST = 32'h0000_0000;
endpackage

// ==== rtl/ssrp_link_if.sv ====
// serial register link between camera controller and sensor port
interface ssrp_link_if;
    logic chip_select_n;
    logic sck;
    logic serial_in;
    logic serial_out;
    modport host (output chip_select_n, output sck, output serial_in,
        input serial_out);
    modport device (input chip_select_n, input sck, input serial_in,
        output serial_out);
endinterface

// ==== rtl/ssrp_device.sv ====
// sensor-side serial register port with the control register page
// Summary of operation
// - lsb first, host drives on fall, device samples rise
// - frame is page byte, address, data bytes
// - write pages 02h-09h, reads add bit 7
// - invalid page byte ignores rest of frame
// - chip select low opens, high closes frame
// - first data at start address, then increment
// - registers commit only whole received bytes
// - write frame shifts out old register contents
// - read frame discards dummies, shifts out contents
// - frame-timed registers apply at frame reflection point
// - immediate registers apply when written
// - update hold blocks frame-timed register updates
// - eight pages of addresses 00h to FEh; only control page 00h-1Fh is stored, the rest read zero
// - host touches listed registers only
// - sleep bit resets to standby, immediate
// - lane standby field picks active channel count
// - timing master stop bit resets to stopped
// - shutter trigger select resets to normal
// - resolution and word width reset to 12 bit
// - drive format field is frame-timed
// - flip bits are frame-timed
// - frame lines and line clocks, frame-timed
//
// Our own choice: the AHB-Lite slave port.
module ssrp_device
    import ssrp_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    ssrp_link_if.device link,
    input wire logic frame_reflect,
    output logic sleep_standby,
    output logic [3:0] lane_standby,
    output logic timing_master_stop,
    output logic shutter_trigger_select,
    output logic conversion_resolution,
    output logic output_word_width,
    output logic [3:0] drive_format,
    output logic vertical_flip,
    output logic horizontal_flip,
    output logic [11:0] frame_lines,
    output logic [15:0] line_clocks
);
    typedef enum logic [1:0] {ST_PAGE, ST_ADDR, ST_DATA, ST_SKIP} ssrp_st_t;

    logic [2:0] cs_sync, sck_sync, sdi_sync;
    logic sck_prev;
    ssrp_st_t state;
    logic [7:0] shreg;
    logic [2:0] bitcnt;
    logic [7:0] addr;
    logic [2:0] page;
    logic rd_frame;
    logic [7:0] outreg;
    logic [7:0] mem [0:31];
    logic [7:0] shadow [0:31];
    logic pend [0:31];

    wire cs_act = ~cs_sync[1];
    wire sck_rise = sck_sync[1] & ~sck_prev;
    wire sck_fall = ~sck_sync[1] & sck_prev;
    wire [7:0] byte_in = {sdi_sync[1], shreg[7:1]};
    wire byte_done = cs_act & sck_rise & (bitcnt == 3'd7);
    wire [7:0] page_raw = byte_in & ~READ_FLAG;
    wire page_ok = (page_raw >= PAGE_FIRST) && (page_raw <= PAGE_LAST);
    wire ctl_page = (page == 3'd0);
    wire [7:0] next_addr = addr + 8'h01;

    function automatic logic frame_timed(input logic [7:0] a);
        frame_timed = (a == OFS_FORMAT) || (a == OFS_FLIP) ||
            (a == OFS_FLINES_LO) || (a == OFS_FLINES_HI) ||
            (a == OFS_LCLK_LO) || (a == OFS_LCLK_HI);
    endfunction

    function automatic logic [7:0] reset_of(input logic [4:0] a);
        unique case ({3'b000, a})
            OFS_SLEEP: reset_of = RST_SLEEP;
            OFS_MSTOP: reset_of = RST_MSTOP;
            OFS_ADRES: reset_of = RST_ADRES;
            OFS_FLINES_LO: reset_of = RST_FLINES_LO;
            OFS_FLINES_HI: reset_of = RST_FLINES_HI;
            OFS_LCLK_LO: reset_of = RST_LCLK_LO;
            OFS_LCLK_HI: reset_of = RST_LCLK_HI;
            OFS_OWIDTH: reset_of = RST_OWIDTH;
            default: reset_of = 8'h00;
        endcase
    endfunction

    // only the control page is stored; other pages read zero
    wire in_map = ctl_page && (addr[7:5] == 3'b000);
    wire [7:0] rd_val = in_map ? mem[addr[4:0]] : 8'h00;
    wire wr_en = (state == ST_DATA) && byte_done && !rd_frame && in_map;
    wire hold = mem[OFS_HOLD[4:0]][0];

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cs_sync <= 3'b111;
            sck_sync <= 3'b000;
            sdi_sync <= 3'b000;
            sck_prev <= 1'b0;
        end
        else
        begin
            cs_sync <= {cs_sync[1:0], link.chip_select_n};
            sck_sync <= {sck_sync[1:0], link.sck};
            sdi_sync <= {sdi_sync[1:0], link.serial_in};
            sck_prev <= sck_sync[1];
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state <= ST_PAGE;
            shreg <= 8'h00;
            bitcnt <= 3'd0;
            addr <= 8'h00;
            page <= 3'd0;
            rd_frame <= 1'b0;
            outreg <= 8'h00;
        end
        else if (!cs_act)
        begin
            state <= ST_PAGE;
            bitcnt <= 3'd0;
            outreg <= 8'h00;
        end
        else
        begin
            if (sck_rise)
            begin
                shreg <= byte_in;
                bitcnt <= bitcnt + 3'd1;
            end
            if (sck_fall && state == ST_DATA)
                outreg <= {1'b0, outreg[7:1]};
            if (byte_done)
            begin
                unique case (state)
                    ST_PAGE:
                    begin
                        state <= page_ok ? ST_ADDR : ST_SKIP;
                        rd_frame <= byte_in[7];
                        page <= 3'(page_raw - PAGE_FIRST);
                    end
                    ST_ADDR:
                    begin
                        state <= ST_DATA;
                        addr <= byte_in;
                    end
                    ST_DATA:
                        addr <= next_addr;
                    ST_SKIP:
                        state <= ST_SKIP;
                endcase
            end
            // load contents at the byte's first fall, before its write at the eighth rise: old value out
            if (sck_fall && bitcnt == 3'd0 && state == ST_DATA)
                outreg <= rd_val;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            for (int i = 0; i < 32; i++)
            begin
                mem[i] <= reset_of(5'(i));
                shadow[i] <= reset_of(5'(i));
                pend[i] <= 1'b0;
            end
        end
        else
        begin
            if (wr_en)
            begin
                mem[addr[4:0]] <= byte_in;
                pend[addr[4:0]] <= frame_timed(addr);
            end
            if (frame_reflect && !hold)
            begin
                for (int i = 0; i < 32; i++)
                begin
                    if (pend[i] && !(wr_en && addr[4:0] == 5'(i)))
                    begin
                        shadow[i] <= mem[i];
                        pend[i] <= 1'b0;
                    end
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            link.serial_out <= 1'b0;
            sleep_standby <= 1'b1;
            lane_standby <= 4'h0;
            timing_master_stop <= 1'b1;
            shutter_trigger_select <= 1'b0;
            conversion_resolution <= 1'b1;
            output_word_width <= 1'b1;
            drive_format <= 4'h0;
            vertical_flip <= 1'b0;
            horizontal_flip <= 1'b0;
            frame_lines <= 12'h4E6;
            line_clocks <= 16'h01CE;
        end
        else
        begin
            link.serial_out <= cs_act & outreg[0];
            sleep_standby <= mem[OFS_SLEEP[4:0]][0];
            lane_standby <= mem[OFS_LANE_STBY[4:0]][7:4];
            timing_master_stop <= mem[OFS_MSTOP[4:0]][0];
            shutter_trigger_select <= mem[OFS_TRIG[4:0]][0];
            conversion_resolution <= mem[OFS_ADRES[4:0]][0];
            output_word_width <= mem[OFS_OWIDTH[4:0]][0];
            drive_format <= shadow[OFS_FORMAT[4:0]][3:0];
            vertical_flip <= shadow[OFS_FLIP[4:0]][0];
            horizontal_flip <= shadow[OFS_FLIP[4:0]][1];
            frame_lines <= {shadow[OFS_FLINES_HI[4:0]][3:0],
                shadow[OFS_FLINES_LO[4:0]]};
            line_clocks <= {shadow[OFS_LCLK_HI[4:0]],
                shadow[OFS_LCLK_LO[4:0]]};
        end
    end
endmodule

// ==== rtl/ssrp_host.sv ====
// camera-controller end: AHB-Lite commands drive three-byte serial frames
module ssrp_host
    import ssrp_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    ssrp_link_if.host link,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata
);
    typedef enum logic [1:0] {HS_IDLE, HS_SHIFT, HS_GAP} ssrp_hst_t;
    // cmd: [7:0] page byte, [15:8] address; write to cmd starts a
    // three-byte frame (page, address, data); reads use dummy data
    logic [15:0] cmd;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic busy;
    ssrp_hst_t state;
    logic [23:0] shreg;
    logic [4:0] bitn;
    logic [3:0] div;
    logic ph_wr;
    logic [7:0] ph_addr;
    logic [1:0] so_sync;

    wire take = hsel & hready & htrans[1];
    wire [7:0] a_byte = ph_addr;
    wire hit_cmd = (a_byte == HOFS_CMD);
    wire tick = (div == 4'(SCK_HALF - 1));
    // read data must stand in the data phase, so decode the live address
    wire [7:0] rd_sel = take ? haddr[7:0] : ph_addr;
    wire [31:0] rd_mux = (rd_sel == HOFS_CMD) ? {16'h0000, cmd} :
        (rd_sel == HOFS_STATUS) ? {31'h0, busy} :
        (rd_sel == HOFS_DATA) ? {24'h0, wdata} :
        (rd_sel == HOFS_RDATA) ? {24'h0, rdata} : 32'h0000_0000;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ph_wr <= 1'b0;
            ph_addr <= 8'h00;
            hrdata <= HRDATA_RST;
        end
        else
        begin
            ph_wr <= take & hwrite;
            ph_addr <= take ? haddr[7:0] : ph_addr;
            if (take && hwrite)
                hrdata <= HRDATA_RST;
            else
                hrdata <= rd_mux;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cmd <= 16'h0000;
            wdata <= 8'h00;
            rdata <= 8'h00;
            busy <= 1'b0;
            state <= HS_IDLE;
            shreg <= 24'h0;
            bitn <= 5'd0;
            div <= 4'd0;
            so_sync <= 2'b00;
            link.chip_select_n <= 1'b1;
            link.sck <= 1'b1;
            link.serial_in <= 1'b0;
        end
        else
        begin
            so_sync <= {so_sync[0], link.serial_out};
            div <= (state == HS_IDLE || tick) ? 4'd0 : div + 4'd1;
            if (ph_wr && !busy && a_byte == HOFS_DATA)
                wdata <= hwdata[7:0];
            unique case (state)
                HS_IDLE:
                    if (ph_wr && hit_cmd && !busy)
                    begin
                        cmd <= hwdata[15:0];
                        busy <= 1'b1;
                        shreg <= {wdata, hwdata[15:8], hwdata[7:0]};
                        bitn <= 5'd0;
                        link.chip_select_n <= 1'b0;
                        state <= HS_SHIFT;
                    end
                HS_SHIFT:
                    if (tick)
                    begin
                        link.sck <= ~link.sck;
                        if (link.sck)
                        begin
                            // falling edge: present next lsb; serial out
                            // has settled four hclk cycles by now, its synchronised copy two
                            link.serial_in <= shreg[0];
                            if (bitn >= 5'd17)
                                rdata <= {so_sync[1], rdata[7:1]};
                            shreg <= {1'b0, shreg[23:1]};
                        end
                        else
                        begin
                            bitn <= bitn + 5'd1;
                            if (bitn == 5'd23)
                                state <= HS_GAP;
                        end
                    end
                HS_GAP:
                    if (tick)
                    begin
                        link.chip_select_n <= 1'b1;
                        rdata <= {so_sync[1], rdata[7:1]};
                        busy <= 1'b0;
                        state <= HS_IDLE;
                    end
            endcase
        end
    end
endmodule

// ==== tb/ssrp_link_properties.sv ====
// protocol checker for the serial register link between the two ends
module ssrp_link_properties (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic chip_select_n,
    input wire logic sck,
    input wire logic serial_in,
    input wire logic serial_out
);
    logic [7:0] bits;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // sck rises per frame, cleared as the next frame opens
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            bits <= 8'h00;
        else if ($fell(chip_select_n))
            bits <= 8'h00;
        else if ($rose(sck))
            bits <= bits + 8'h01;
    end
    idle_out_low_a: assert property (
        chip_select_n [*4] |-> !serial_out)
        else $error("serial out active while deselected");
    sdi_setup_a: assert property (
        $rose(sck) && !chip_select_n |-> $stable(serial_in))
        else $error("serial in moved at sck rise");
    sdi_hold_a: assert property (
        $rose(sck) && !chip_select_n |=> $stable(serial_in))
        else $error("serial in moved just after sck rise");
    sck_still_a: assert property (
        chip_select_n [*3] |-> $stable(sck))
        else $error("sck toggles outside a frame");
    sck_high_a: assert property (
        $rose(sck) && !chip_select_n |-> sck [*4])
        else $error("sck high phase too short");
    sck_low_a: assert property (
        $fell(sck) |-> (!sck) [*4] ##1 sck)
        else $error("sck low phase wrong length");
    sck_in_frame_a: assert property (
        $fell(sck) |-> !chip_select_n)
        else $error("sck falls while deselected");
    frame_bits_a: assert property (
        $rose(chip_select_n) |-> bits == 8'h18)
        else $error("frame closed with wrong bit count");
    cs_gap_a: assert property (
        $rose(chip_select_n) |-> chip_select_n [*4])
        else $error("deselect gap too short");
    out_steady_a: assert property (
        !chip_select_n && sck && $past(sck) && $past(sck, 2)
        |-> $stable(serial_out))
        else $error("serial out moved while sck high");
    cover property ($rose(chip_select_n));
    cover property (!chip_select_n && serial_out);
    cover property ($rose(sck) && serial_in);
endmodule

// ==== tb/sensor_serial_register_port_tb.sv ====
// bench: AHB-Lite host end facing the sensor port end over the link
module sensor_serial_register_port_tb;
    import ssrp_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic frame_reflect, sleep_standby, timing_master_stop;
    logic shutter_trigger_select, conversion_resolution;
    logic output_word_width, vertical_flip, horizontal_flip;
    logic [3:0] lane_standby, drive_format;
    logic [11:0] frame_lines;
    logic [15:0] line_clocks;
    int error_cnt = 0;
    int checks_done = 0;
    int cycles = 0;
    int mem[32];
    int app[32];
    logic [7:0] ofs[13] = '{8'h00, 8'h05, 8'h0C, 8'h12, 8'h13, 8'h14,
        8'h15, 8'h16, 8'h17, 8'h18, 8'h1A, 8'h1B, 8'h1C};
    int resv[13] = '{1, 0, 0, 1, 0, 1, 0, 0, 'hE6, 4, 'hCE, 1, 'h11};
    logic [7:0] imm[5] = '{8'h12, 8'h13, 8'h14, 8'h1C, 8'h00};
    logic [7:0] bad[4] = '{8'h01, 8'h0A, 8'h42, 8'hFF};
    ssrp_link_if link();
    assign hready = hreadyout;
    ssrp_host i_ssrp_host (.hclk, .hresetn, .link, .hsel, .haddr, .htrans,
        .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata);
    ssrp_device i_ssrp_device (.hclk, .hresetn, .link, .frame_reflect,
        .sleep_standby, .lane_standby, .timing_master_stop,
        .shutter_trigger_select, .conversion_resolution, .output_word_width,
        .drive_format, .vertical_flip, .horizontal_flip, .frame_lines,
        .line_clocks);
    ssrp_link_properties i_ssrp_link_properties (.hclk, .hresetn,
        .chip_select_n(link.chip_select_n), .sck(link.sck),
        .serial_in(link.serial_in), .serial_out(link.serial_out));
    initial
    begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // a hung frame would otherwise stall the run forever
    always @(posedge hclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 60000)
        begin
            error_cnt++;
            conclude();
        end
    end
    task automatic chk(input string what, input logic [15:0] exp,
        input logic [15:0] got);
        checks_done++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    // one three-byte frame; busy is set one edge late, hence the gap
    task automatic frame(input logic [7:0] pg, a, d, output logic [7:0] got);
        int n;
        bus(1'b1, HOFS_DATA, {24'h000000, d});
        bus(1'b1, HOFS_CMD, {16'h0000, a, pg});
        repeat (2) @(posedge hclk);
        n = 0;
        do
        begin
            bus(1'b0, HOFS_STATUS, 32'h00000000);
            n++;
        end
        while (rd[0] !== 1'b0 && n < 400);
        bus(1'b0, HOFS_RDATA, 32'h00000000);
        got = rd[7:0];
        repeat (8) @(posedge hclk);
    endtask
    task automatic wr(input logic [7:0] pg, a, d);
        logic [7:0] got;
        frame(pg, a, d, got);
        if (pg == 8'h02)
        begin
            chk("old byte", 16'(mem[a]), {8'h00, got});
            mem[a] = d;
        end
        else if (pg == 8'h03)
            chk("other page", 16'h0000, {8'h00, got});
    endtask
    task automatic rd_all(input logic [7:0] pg);
        logic [7:0] got;
        foreach (ofs[i])
        begin
            frame(pg, ofs[i], 8'($urandom), got);
            chk("read byte", pg == 8'h82 ? 16'(mem[ofs[i]]) : 16'h0000,
                {8'h00, got});
        end
    endtask
    task automatic chk_outs();
        chk("sleep", 16'(mem[0] & 1), {15'h0, sleep_standby});
        chk("lanes", 16'(mem[5] >> 4), {12'h0, lane_standby});
        chk("mstop", 16'(mem[18] & 1), {15'h0, timing_master_stop});
        chk("trig", 16'(mem[19] & 1), {15'h0, shutter_trigger_select});
        chk("adres", 16'(mem[20] & 1), {15'h0, conversion_resolution});
        chk("owidth", 16'(mem[28] & 1), {15'h0, output_word_width});
        chk("format", 16'(app[21] & 15), {12'h0, drive_format});
        chk("flip", 16'(app[22] & 3),
            {14'h0, horizontal_flip, vertical_flip});
        chk("lines", 16'(app[24] % 16 * 256 + app[23]),
            {4'h0, frame_lines});
        chk("clocks", 16'(app[27] * 256 + app[26]), line_clocks);
    endtask
    // hold bit is sampled at the pulse, as the device does
    task automatic reflect();
        frame_reflect <= 1'b1;
        @(posedge hclk);
        frame_reflect <= 1'b0;
        repeat (4) @(posedge hclk);
        if ((mem[12] & 1) == 0)
            app = mem;
    endtask
    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h00000000;
        frame_reflect = 1'b0;
        void'($urandom(44177));
        foreach (ofs[i])
            mem[ofs[i]] = resv[i];
        app = mem;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk_outs();
        rd_all(8'h82);
        chk_outs();
        $display("test reset values done");
        for (int k = 1; k < 4; k++)
        begin
            wr(8'h02, 8'h05, 8'(k % 3 * 16));
            chk_outs();
        end
        foreach (imm[i])
        begin
            wr(8'h02, imm[i], 8'(mem[imm[i]] ^ 1));
            chk_outs();
        end
        $display("test immediate registers done");
        wr(8'h02, 8'h0C, 8'h01);
        for (int k = 0; k < 4; k++)
        begin
            wr(8'h02, 8'h15, 8'((k + 1) * 2 % 6));
            wr(8'h02, 8'h16, 8'($urandom % 4));
            wr(8'h02, 8'h17, 8'($urandom));
            wr(8'h02, 8'h18, 8'($urandom % 16));
            wr(8'h02, 8'h1A, 8'($urandom));
            wr(8'h02, 8'h1B, 8'($urandom));
            chk_outs();
            reflect();
            chk_outs();
            if (k == 0)
                wr(8'h02, 8'h0C, 8'h00);
        end
        rd_all(8'h82);
        $display("test frame timed registers done");
        foreach (bad[i])
            wr(bad[i], 8'h00, 8'(mem[0] ^ 1));
        chk_outs();
        wr(8'h03, 8'h00, 8'h5A);
        rd_all(8'h83);
        chk_outs();
        $display("test page selection done");
        conclude();
    end
endmodule
